// ==== hdl/pcic_cfg.svh ====
// Behaviour
// - per pin, source select picks change or compare
// - change mode fires on level opposite reference
// - reference reloads from pin after clear
// - compare mode fires on mismatch with default
// - compare mismatch persists across port reads
// - one interrupt per port, cleared by read
// - only enabled input pins contribute
// - event copies whole port into capture
// - pending interrupt blocks new events, capture frozen
`ifndef PCIC_CFG_SVH
`define PCIC_CFG_SVH
// ----------------------------------------
// reset values
// ----------------------------------------
`define PCIC_RST_CAPTURE 8'h00
`define PCIC_RST_REF     8'h00
`define PCIC_RST_SYNC    8'h00
`define PCIC_RST_FLAGS   8'h00
`endif

// ==== hdl/pcic_pkg.sv ====
package pcic_pkg;
  typedef logic [7:0] pcic_byte_t;
  // per-pin configuration from the register block
  typedef struct packed {
    pcic_byte_t pin_direction;
    pcic_byte_t change_interrupt_enable;
    pcic_byte_t interrupt_source_select;
    pcic_byte_t compare_default_value;
  } pcic_cfg_s;
  // read strobes from the serial side
  typedef struct packed {
    logic port_read;
    logic capture_read;
  } pcic_rd_s;
  typedef enum logic {
    PCIC_IDLE,
    PCIC_PENDING
  } pcic_state_e;
endpackage : pcic_pkg

// ==== hdl/pcic_sync.sv ====
`timescale 1ns/10ps
`include "pcic_cfg.svh"
module pcic_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  // ----------------------------------------
  // two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stage1   <= WIDTH'(`PCIC_RST_SYNC);
      sync_out <= WIDTH'(`PCIC_RST_SYNC);
    end else if (clk_en) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pcic_sync

// ==== hdl/pcic_top.sv ====
`timescale 1ns/10ps
`include "pcic_cfg.svh"
module pcic_top
  import pcic_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire logic [7:0]          pin_in,
  input  wire pcic_pkg::pcic_cfg_s cfg,
  input  wire pcic_pkg::pcic_rd_s  rd,
  output logic      [7:0]          port_value,
  output logic      [7:0]          captured_port_value,
  output logic      [7:0]          interrupt_flags,
  output logic                     port_interrupt
);
  import pcic_pkg::*;

  // ----------------------------------------
  // state and internal nets
  // ----------------------------------------
  pcic_state_e state;
  logic [7:0]  pin_sync;
  logic [7:0]  reference;
  logic [7:0]  input_pins;
  logic [7:0]  enabled_pins;
  logic [7:0]  compare_mode;
  logic [7:0]  default_level;
  logic [7:0]  eligible;
  logic [7:0]  compare_pins;
  logic [7:0]  change_pins;
  logic [7:0]  change_hit;
  logic [7:0]  compare_hit;
  logic [7:0]  cond;

  logic        any_cond;
  logic        idle;
  logic        pending;
  logic        read_port;
  logic        read_capture;
  logic        read_now;
  logic        clear_now;
  logic        event_now;
  logic        reload_ref;
  logic        track_ref;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // input pins with change interrupt enabled
  function automatic logic [7:0] pin_eligible(
    input logic [7:0] dir,
    input logic [7:0] en
  );
    logic [7:0] e;
    e = dir & en;
    return e;
  endfunction : pin_eligible

  // per-pin difference of two levels, limited to the selected pins
  function automatic logic [7:0] masked_diff(
    input logic [7:0] lvl,
    input logic [7:0] cmp,
    input logic [7:0] sel
  );
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (sel[i]) begin
        d[i] = lvl[i] ^ cmp[i];
      end else begin
        d[i] = 1'b0;
      end
    end
    return d;
  endfunction : masked_diff

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  // two flops, so a pin moving near the edge cannot split a compare
  pcic_sync #(
    .WIDTH(8)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // ----------------------------------------
  // port value output
  // ----------------------------------------
  // second synchroniser stage doubles as the registered port value
  assign port_value = pin_sync;

  // ----------------------------------------
  // configuration fields
  // ----------------------------------------
  assign input_pins    = cfg.pin_direction;
  assign enabled_pins  = cfg.change_interrupt_enable;
  assign compare_mode  = cfg.interrupt_source_select;
  assign default_level = cfg.compare_default_value;

  // ----------------------------------------
  // eligibility and mode split
  // ----------------------------------------
  assign eligible     = pin_eligible(input_pins, enabled_pins);
  assign compare_pins = eligible & compare_mode;
  assign change_pins  = eligible & ~compare_mode;

  // ----------------------------------------
  // condition per pin
  // ----------------------------------------
  // change mode: pin now opposite its reference level
  assign change_hit  = masked_diff(pin_sync, reference, change_pins);
  // compare mode: holds while the mismatch lasts, reads do not mask it
  assign compare_hit = masked_diff(pin_sync, default_level,
                                   compare_pins);
  // a pin is in one mode only, so the two hits never overlap
  assign cond        = change_hit | compare_hit;
  assign any_cond    = |cond;

  // ----------------------------------------
  // read strobes
  // ----------------------------------------
  assign read_port    = rd.port_read;
  assign read_capture = rd.capture_read;
  // either read of this port clears it
  assign read_now     = read_port | read_capture;

  // ----------------------------------------
  // state decode
  // ----------------------------------------
  assign idle       = (state == PCIC_IDLE);
  assign pending    = (state == PCIC_PENDING);
  // an event needs idle and a clear needs pending, so they never meet
  assign clear_now  = pending & read_now;
  assign event_now  = idle & any_cond;
  assign reload_ref = clear_now;
  // tracking makes the reference the level of the previous cycle
  assign track_ref  = idle & ~event_now;

  // ----------------------------------------
  // interrupt state
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= PCIC_IDLE;
    end else if (clk_en) begin
      case (state)
        PCIC_IDLE: begin
          if (event_now) begin
            state <= PCIC_PENDING;
          end
        end
        PCIC_PENDING: begin
          if (clear_now) begin
            state <= PCIC_IDLE;
          end
        end
        // an unknown (X) state value falls back to idle
        default: begin
          state <= PCIC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  assign port_interrupt = pending;

  // ----------------------------------------
  // capture register
  // ----------------------------------------
  // a later condition must not overwrite the first snapshot
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      captured_port_value <= `PCIC_RST_CAPTURE;
    end else if (clk_en) begin
      if (event_now) begin
        captured_port_value <= pin_sync;
      end
    end
  end

  // ----------------------------------------
  // interrupt flags
  // ----------------------------------------
  // cause of the pending interrupt, gone once it is cleared
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      interrupt_flags <= `PCIC_RST_FLAGS;
    end else if (clk_en) begin
      if (event_now) begin
        interrupt_flags <= cond;
      end else if (clear_now) begin
        interrupt_flags <= `PCIC_RST_FLAGS;
      end
    end
  end

  // ----------------------------------------
  // reference level
  // ----------------------------------------
  // follows the pins while quiet, reloads from them at clear
  // reset level 0: a pin high at reset in change mode fires once
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reference <= `PCIC_RST_REF;
    end else if (clk_en) begin
      if (reload_ref) begin
        reference <= pin_sync;
      end else if (track_ref) begin
        reference <= pin_sync;
      end
    end
  end
endmodule : pcic_top

// ==== verif/pcic_top_assertions.sv ====
`timescale 1ns/10ps
module pcic_top_assertions
  import pcic_pkg::*;
(
  input wire logic                mclk,
  input wire logic                sys_rst,
  input wire logic                clk_en,
  input wire logic [7:0]          pin_in,
  input wire pcic_pkg::pcic_cfg_s cfg,
  input wire pcic_pkg::pcic_rd_s  rd,
  input wire logic [7:0]          interrupt_flags,
  input wire logic [7:0]          captured_port_value,
  input wire logic                port_interrupt
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [7:0] m;
  logic       rdp;
  assign m   = (pin_in ^ cfg.compare_default_value) & cfg.pin_direction
             & cfg.change_interrupt_enable & cfg.interrupt_source_select;
  assign rdp = rd.port_read | rd.capture_read;
  AST_PEND_HOLD: assert property (port_interrupt && !rdp && clk_en |=> port_interrupt)
    else $error("pending interrupt dropped");
  AST_CAP_FROZEN: assert property (port_interrupt && !rdp && clk_en |=>
    $stable(captured_port_value)) else $error("capture moved while pending");
  AST_CLEAR: assert property (port_interrupt && rdp && clk_en |=> !port_interrupt)
    else $error("read did not clear");
  AST_FLAGS_IDLE: assert property (!port_interrupt |-> interrupt_flags == 8'h00)
    else $error("flags set while idle");
  AST_FLAGS_CAUSE: assert property ($rose(port_interrupt) |-> interrupt_flags != 8'h00)
    else $error("interrupt without cause");
  AST_FLAGS_MASK: assert property ($rose(port_interrupt) && $stable(cfg) |->
    (interrupt_flags & ~(cfg.pin_direction & cfg.change_interrupt_enable)) == 8'h00)
    else $error("masked pin flagged");
  AST_CMP_PERSIST: assert property (port_interrupt && rdp && clk_en && m != 8'h00 &&
    $past(clk_en) && $stable(pin_in) && $stable(cfg) ##1 clk_en && $stable(cfg) |->
    !port_interrupt ##1 port_interrupt) else $error("mismatch did not re-assert");
  AST_CMP_FIRE: assert property (!port_interrupt && clk_en && m != 8'h00 &&
    $past(clk_en) && $past(clk_en, 2) && !$past(sys_rst) && !$past(sys_rst, 2) &&
    $stable(pin_in) && $past(pin_in, 2) == pin_in && $stable(cfg) |=> port_interrupt)
    else $error("mismatch did not fire");
endmodule : pcic_top_assertions
bind pcic_top pcic_top_assertions u_chk (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
  .pin_in(pin_in), .cfg(cfg), .rd(rd), .interrupt_flags(interrupt_flags),
  .captured_port_value(captured_port_value), .port_interrupt(port_interrupt));

// ==== verif/pcic_master.sv ====
`timescale 1ns/10ps
module pcic_master
  import pcic_pkg::*;
(
  input wire logic                mclk,
  output pcic_pkg::pcic_rd_s      rd
);
  initial rd = 2'b00;
  // one-cycle read strobe of port or capture
  task automatic read_pulse(input logic [1:0] k);
    @(negedge mclk) rd = k;
    @(negedge mclk) rd = 2'b00;
  endtask : read_pulse
endmodule : pcic_master

// ==== verif/pcic_top_tb_top.sv ====
`timescale 1ns/10ps
module pcic_top_tb_top;
  import pcic_pkg::*;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR %0t %h %h", $time, a, b); end end
  logic       mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, irq;
  logic [7:0] pin_in = 8'h00, lf = 8'h2f, v, old, m, pv, cap, flags;
  pcic_cfg_s  cfg = 32'h00000000;
  pcic_rd_s   rd;
  int         n_mismatch = 0, n_checks = 0;
  pcic_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .pin_in(pin_in), .cfg(cfg),
    .rd(rd), .port_value(pv), .captured_port_value(cap), .interrupt_flags(flags),
    .port_interrupt(irq));
  pcic_master u_m (.mclk(mclk), .rd(rd));
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  function automatic logic [7:0] exp_flags(input logic [7:0] a, b, input pcic_cfg_s c);
    return (a ^ b) & c.pin_direction & c.change_interrupt_enable & ~c.interrupt_source_select;
  endfunction : exp_flags
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_n
  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  initial forever #50 mclk = ~mclk;
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    wait_n(16);
    sys_rst = 1'b0;
    old = 8'h00;
    for (int i = 0; i < 12; i++) begin
      lf = nxt(lf);
      cfg = {lf | 8'h81, 8'hff, 8'h00, 8'h00};
      lf = nxt(lf);
      v = lf;
      pin_in = v;
      wait_n(1);
      `CHK(pv, old)
      wait_n(3);
      `CHK(pv, v)
      m = exp_flags(v, old, cfg);
      `CHK(irq, |m)
      if (|m) begin
        `CHK(flags, m)
        `CHK(cap, v)
        pin_in = ~v;
        wait_n(4);
        `CHK(cap, v)
        `CHK(flags, m)
        u_m.read_pulse(i[0] ? 2'b10 : 2'b01);
        `CHK(irq, 1'b0)
        wait_n(4);
        `CHK(irq, 1'b0)
      end
      old = pin_in;
    end
    lf = nxt(lf);
    cfg = {8'hff, 8'h00, 8'hff, lf};
    pin_in = lf ^ 8'h80;
    wait_n(4);
    cfg.change_interrupt_enable = 8'hff;
    wait_n(2);
    `CHK(flags, 8'h80)
    u_m.read_pulse(2'b10);
    `CHK(irq, 1'b0)
    wait_n(1);
    `CHK(irq, 1'b1)
    pin_in = lf;
    wait_n(3);
    u_m.read_pulse(2'b01);
    wait_n(2);
    `CHK(irq, 1'b0)
    clk_en = 1'b0;
    pin_in = lf ^ 8'h01;
    wait_n(4);
    `CHK(pv, lf)
    `CHK(irq, 1'b0)
    clk_en = 1'b1;
    wait_n(4);
    `CHK(flags, 8'h01)
    `CHK(cap, lf ^ 8'h01)
    print_verdict();
  end
endmodule : pcic_top_tb_top
